// *** common/keying_pkg.sv ***
package keying_pkg;
	// ----------------------------------------------------------------
	// Timing base
	// ----------------------------------------------------------------
	localparam int CLK_HZ      = 10_000_000;
	localparam int TICK_MS     = 1;                        // Tick period in ms
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;  // Clock cycles per tick

	// ----------------------------------------------------------------
	// Marker keying patterns, in ms
	// ----------------------------------------------------------------
	localparam logic [15:0] MK_LONG_ON_MS  = 16'd375;
	localparam logic [15:0] MK_LONG_OFF_MS = 16'd125;
	localparam logic [15:0] MK_SHORT_MS    = 16'd83;
	localparam logic [1:0]  MK_PHASES_TWO  = 2'd1;         // Last phase index, two phases
	localparam logic [1:0]  MK_PHASES_FOUR = 2'd3;         // Last phase index, four phases

	// ----------------------------------------------------------------
	// Morse timing and code layout
	// ----------------------------------------------------------------
	localparam logic [1:0] STD_RATIO   = 2'd3;             // Dash and letter gap in dots
	localparam int         CODE_ELEMS  = 16;
	localparam int         ELEM_DASH   = 0;                // Element bit: dash, else dot
	localparam int         ELEM_LETEND = 1;                // Element bit: last of a letter

	// ----------------------------------------------------------------
	// Carrier and tone defaults and limits
	// ----------------------------------------------------------------
	localparam logic [11:0] DF_MIN_KHZ       = 12'd190;
	localparam logic [11:0] DF_MAX_KHZ       = 12'd1750;
	localparam logic [11:0] DF_DEFAULT_KHZ   = 12'd190;
	localparam logic [15:0] IDENT_DEFAULT_HZ = 16'd1020;

	typedef enum logic [1:0] {MK_OUTER, MK_MIDDLE, MK_INNER, MK_SPARE} marker_type_e;
	typedef enum logic [2:0] {ID_IDLE, ID_MARK, ID_GAP, ID_LGAP, ID_WAIT} ident_state_e;
endpackage : keying_pkg

// *** rtl/avionic_morse_keying_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module avionic_morse_keying_timer #(
	parameter int TICK_CYCLES = keying_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// Standard activation requests, one-cycle pulses
	input  wire logic        activate_vor,
	input  wire logic        activate_landing,
	input  wire logic        activate_df,
	input  wire logic        deactivate_all,
	input  wire logic        set_defaults,
	// Carrier and ident tone settings
	input  wire logic        carrier_wr,
	input  wire logic [11:0] carrier_khz_in,
	input  wire logic        ident_freq_wr,
	input  wire logic [15:0] ident_freq_in,
	// Marker settings
	input  wire logic        pulsed_marker,
	input  wire logic [1:0]  marker_type,
	// Ident settings
	input  wire logic        ident_enable,
	input  wire logic [31:0] code_elems,
	input  wire logic [4:0]  code_count,
	input  wire logic        user_scheme,
	input  wire logic [15:0] dot_ms,
	input  wire logic [15:0] dash_ms,
	input  wire logic [15:0] sym_ms,
	input  wire logic [15:0] letter_ms,
	input  wire logic [15:0] period_ms,
	// Status and keying
	output logic             vor_mode,
	output logic             landing_system_mode,
	output logic             direction_finder_mode,
	output logic             conflict,
	output logic [11:0]      carrier_khz,
	output logic [15:0]      ident_freq_hz,
	output logic             marker_key,
	output logic             ident_tone
);
	logic                     tick;
	logic                     in_range;
	logic [1:0]               mk_phase;
	logic [15:0]              mk_ms;
	logic [1:0]               mk_type_q;
	logic [15:0]              mk_len;
	logic [1:0]               mk_last;
	logic [17:0]              eff_dot, eff_dash, eff_sym, eff_letter;
	keying_pkg::ident_state_e id_state;
	logic [3:0]               idx;
	logic [17:0]              id_ms;
	logic [15:0]              per_ms;
	logic [17:0]              id_len;
	logic [1:0]               elem;
	logic                     restart;
	logic                     last_elem;

	// ----------------------------------------------------------------
	// Millisecond tick
	// ----------------------------------------------------------------
	ms_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
		.clk  (clk),
		.rst_b(rst_b),
		.tick (tick)
	);

	// ----------------------------------------------------------------
	// Carrier, tone frequency and standard selection
	// ----------------------------------------------------------------
	assign in_range = (carrier_khz >= keying_pkg::DF_MIN_KHZ) &&
		(carrier_khz <= keying_pkg::DF_MAX_KHZ);

	// Defaults beat a write in the same cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			carrier_khz   <= keying_pkg::DF_DEFAULT_KHZ;
			ident_freq_hz <= keying_pkg::IDENT_DEFAULT_HZ;
		end else if (set_defaults) begin
			carrier_khz   <= keying_pkg::DF_DEFAULT_KHZ;
			ident_freq_hz <= keying_pkg::IDENT_DEFAULT_HZ;
		end else begin
			if (carrier_wr)
				carrier_khz <= carrier_khz_in;
			if (ident_freq_wr)
				ident_freq_hz <= ident_freq_in;
		end
	end

	// Activation state ignores set_defaults; a vor or landing request is taken
	// even out of range, a df request only when the carrier is in range
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			vor_mode              <= 1'b0;
			landing_system_mode   <= 1'b0;
			direction_finder_mode <= 1'b0;
			conflict              <= 1'b0;
		end else begin
			conflict <= !in_range;
			if (activate_df && in_range) begin
				vor_mode              <= 1'b0;
				landing_system_mode   <= 1'b0;
				direction_finder_mode <= 1'b1;
			end else if (activate_landing) begin
				vor_mode              <= 1'b0;
				landing_system_mode   <= 1'b1;
				direction_finder_mode <= 1'b0;
			end else if (activate_vor) begin
				vor_mode              <= 1'b1;
				landing_system_mode   <= 1'b0;
				direction_finder_mode <= 1'b0;
			end else if (deactivate_all) begin
				vor_mode              <= 1'b0;
				landing_system_mode   <= 1'b0;
				direction_finder_mode <= 1'b0;
			end else if (!in_range) begin
				direction_finder_mode <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Marker keying
	// ----------------------------------------------------------------
	// Phase length and last phase by marker tone
	always_comb begin
		mk_last = keying_pkg::MK_PHASES_TWO;
		mk_len  = mk_phase[0] ? keying_pkg::MK_LONG_OFF_MS : keying_pkg::MK_LONG_ON_MS;
		case (marker_type)
			keying_pkg::MK_MIDDLE: begin
				mk_last = keying_pkg::MK_PHASES_FOUR;
				if (mk_phase[1])
					mk_len = keying_pkg::MK_SHORT_MS;
			end
			keying_pkg::MK_INNER: mk_len = keying_pkg::MK_SHORT_MS;
			default: ;
		endcase
	end

	// A change of marker tone restarts its pattern from the first on phase
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mk_phase  <= 2'h0;
			mk_ms     <= 16'h0000;
			mk_type_q <= 2'h0;
		end else begin
			mk_type_q <= marker_type;
			if (!pulsed_marker || marker_type != mk_type_q) begin
				mk_phase <= 2'h0;
				mk_ms    <= 16'h0000;
			end else if (tick) begin
				if (mk_ms + 16'h0001 >= mk_len) begin
					mk_ms    <= 16'h0000;
					mk_phase <= (mk_phase >= mk_last) ? 2'h0 : mk_phase + 2'h1;
				end else begin
					mk_ms <= mk_ms + 16'h0001;
				end
			end
		end
	end

	// Even phases are on
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			marker_key <= 1'b1;
		else
			marker_key <= !pulsed_marker || !mk_phase[0];
	end

	// ----------------------------------------------------------------
	// Ident Morse timing
	// ----------------------------------------------------------------
	// Registered to keep the multiply off the counter compare path
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			eff_dot    <= 18'h00000;
			eff_dash   <= 18'h00000;
			eff_sym    <= 18'h00000;
			eff_letter <= 18'h00000;
		end else begin
			eff_dot <= {2'h0, dot_ms};
			if (user_scheme) begin
				eff_dash   <= {2'h0, dash_ms};
				eff_sym    <= {2'h0, sym_ms};
				eff_letter <= {2'h0, letter_ms};
			end else begin
				eff_dash   <= 18'({2'h0, dot_ms} * keying_pkg::STD_RATIO);
				eff_sym    <= {2'h0, dot_ms};
				eff_letter <= 18'({2'h0, dot_ms} * keying_pkg::STD_RATIO);
			end
		end
	end

	assign elem      = code_elems[{idx, 1'b0} +: 2];
	assign last_elem = {1'b0, idx} == 5'(code_count - 5'h01);
	assign restart   = tick && (per_ms + 16'h0001 >= period_ms);

	// Current element or gap length; zero lengths act as 1 ms
	always_comb begin
		case (id_state)
			keying_pkg::ID_MARK: id_len = elem[keying_pkg::ELEM_DASH] ? eff_dash : eff_dot;
			keying_pkg::ID_GAP:  id_len = eff_sym;
			keying_pkg::ID_LGAP: id_len = eff_letter;
			default:             id_len = eff_dot;
		endcase
	end

	// Sequencer; a period shorter than the code cuts the code short
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			id_state <= keying_pkg::ID_IDLE;
			idx      <= 4'h0;
			id_ms    <= 18'h00000;
			per_ms   <= 16'h0000;
		end else if (!ident_enable || code_count == 5'h00) begin
			id_state <= keying_pkg::ID_IDLE;
			idx      <= 4'h0;
			id_ms    <= 18'h00000;
			per_ms   <= 16'h0000;
		end else if (id_state == keying_pkg::ID_IDLE || restart) begin
			id_state <= keying_pkg::ID_MARK;
			idx      <= 4'h0;
			id_ms    <= 18'h00000;
			per_ms   <= 16'h0000;
		end else if (tick) begin
			per_ms <= per_ms + 16'h0001;
			if (id_ms + 18'h00001 >= id_len) begin
				id_ms <= 18'h00000;
				case (id_state)
					keying_pkg::ID_MARK: begin
						if (last_elem)
							id_state <= keying_pkg::ID_WAIT;
						else if (elem[keying_pkg::ELEM_LETEND])
							id_state <= keying_pkg::ID_LGAP;
						else
							id_state <= keying_pkg::ID_GAP;
					end
					keying_pkg::ID_GAP, keying_pkg::ID_LGAP: begin
						idx      <= idx + 4'h1;
						id_state <= keying_pkg::ID_MARK;
					end
					default: id_state <= id_state;
				endcase
			end else begin
				id_ms <= id_ms + 18'h00001;
			end
		end
	end

	// Key output: down with no code, Morse otherwise, silent when disabled
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			ident_tone <= 1'b0;
		else
			ident_tone <= ident_enable &&
				(code_count == 5'h00 || id_state == keying_pkg::ID_MARK);
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	AST_ONE_STANDARD: assert property (@(posedge clk) disable iff (!rst_b)
		$onehot0({vor_mode, landing_system_mode, direction_finder_mode}))
		else $error("more than one avionic standard active");
	AST_DF_REFUSED: assert property (@(posedge clk) disable iff (!rst_b)
		!in_range |=> !direction_finder_mode && conflict)
		else $error("direction finder active with carrier out of range");
	AST_DEFAULT_VALUES: assert property (@(posedge clk) disable iff (!rst_b)
		set_defaults |=> carrier_khz == 12'd190 && ident_freq_hz == 16'd1020)
		else $error("defaults not restored");
	AST_DEFAULT_KEEPS_STATE: assert property (@(posedge clk) disable iff (!rst_b)
		set_defaults && !activate_vor && !activate_landing && !activate_df &&
		!deactivate_all && in_range |=> $stable(landing_system_mode) && $stable(vor_mode) &&
		$stable(direction_finder_mode))
		else $error("defaults changed activation state");
	AST_MARKER_CONT: assert property (@(posedge clk) disable iff (!rst_b)
		!pulsed_marker |=> marker_key)
		else $error("unpulsed marker not keyed on");
	AST_MARKER_BOUND: assert property (@(posedge clk) disable iff (!rst_b)
		pulsed_marker && $stable(marker_type) && marker_type != keying_pkg::MK_MIDDLE
		|-> mk_ms < 16'd375 && mk_phase <= 2'd1)
		else $error("outer or inner marker phase overran");
	AST_MIDDLE_SHORT: assert property (@(posedge clk) disable iff (!rst_b)
		pulsed_marker && $stable(marker_type) && marker_type == keying_pkg::MK_MIDDLE &&
		mk_phase[1] |-> mk_ms < 16'd83)
		else $error("middle marker short element overran");
	AST_INNER_SHORT: assert property (@(posedge clk) disable iff (!rst_b)
		pulsed_marker && $stable(marker_type) && marker_type == keying_pkg::MK_INNER
		|-> mk_ms < 16'd83)
		else $error("inner marker element overran");
	AST_IDENT_OFF: assert property (@(posedge clk) disable iff (!rst_b)
		!ident_enable |=> !ident_tone)
		else $error("ident keyed while disabled");
	AST_KEY_DOWN: assert property (@(posedge clk) disable iff (!rst_b)
		ident_enable && code_count == 5'h00 |=> ident_tone)
		else $error("empty code not key down");
	AST_STD_DASH: assert property (@(posedge clk) disable iff (!rst_b)
		!user_scheme |=> eff_dash == 18'({2'h0, $past(dot_ms)} * 2'd3)
		&& eff_sym == {2'h0, $past(dot_ms)})
		else $error("standard scheme lengths wrong");
	AST_USER_DASH: assert property (@(posedge clk) disable iff (!rst_b)
		user_scheme |=> eff_dash == {2'h0, $past(dash_ms)} && eff_letter == {2'h0, $past(letter_ms)})
		else $error("user dash length not taken");
	AST_IDENT_RESTART: assert property (@(posedge clk) disable iff (!rst_b)
		ident_enable && code_count != 5'h00 && id_state != keying_pkg::ID_IDLE && restart
		|=> id_state == keying_pkg::ID_MARK && idx == 4'h0 && per_ms == 16'h0000)
		else $error("ident did not restart at period end");

	COV_MIDDLE_SHORT: cover property (@(posedge clk) disable iff (!rst_b)
		pulsed_marker && marker_type == keying_pkg::MK_MIDDLE && mk_phase == 2'd3);
	COV_IDENT_LGAP: cover property (@(posedge clk) disable iff (!rst_b)
		id_state == keying_pkg::ID_LGAP);
	COV_DF_ACTIVE: cover property (@(posedge clk) disable iff (!rst_b)
		direction_finder_mode);
	COV_IDENT_WAIT: cover property (@(posedge clk) disable iff (!rst_b)
		id_state == keying_pkg::ID_WAIT && restart);
endmodule : avionic_morse_keying_timer
`default_nettype wire

// *** rtl/ms_tick_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
module ms_tick_gen #(
	parameter int TICK_CYCLES = keying_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// Tick out
	output logic      tick
);
	logic [15:0] cnt;

	// Free divider; the tick is a one-cycle enable, never a clock
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt  <= 16'h0000;
			tick <= 1'b0;
		end else if (cnt == 16'(TICK_CYCLES - 1)) begin
			cnt  <= 16'h0000;
			tick <= 1'b1;
		end else begin
			cnt  <= cnt + 16'h0001;
			tick <= 1'b0;
		end
	end

	AST_TICK_PULSE: assert property (@(posedge clk) disable iff (!rst_b)
		tick |=> !tick) else $error("tick lasted more than one cycle");
endmodule : ms_tick_gen
`default_nettype wire

// *** verif/avionic_morse_keying_timer_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module avionic_morse_keying_timer_test;
	// ----------------------------------------------------------------
	// Bench signals
	// ----------------------------------------------------------------
	localparam int TC = 10;                // Short tick keeps the run small
	logic        clk            = 1'b0;
	logic        rst_b          = 1'b0;
	logic [3:0]  req            = 4'h0;   // vor, landing, df, deactivate
	logic        set_defaults   = 1'b0;
	logic        carrier_wr     = 1'b0;
	logic [11:0] carrier_khz_in = 12'h0be;
	logic        ident_freq_wr  = 1'b0;
	logic [15:0] ident_freq_in  = 16'h0000;
	logic        pulsed_marker  = 1'b0;
	logic [1:0]  marker_type    = 2'h0;
	logic        ident_enable   = 1'b0;
	logic [31:0] code_elems     = 32'h0;
	logic [4:0]  code_count     = 5'h00;
	logic        user_scheme    = 1'b0;
	logic [15:0] dot_ms         = 16'h0001;
	logic [15:0] dash_ms        = 16'h0003;
	logic [15:0] sym_ms         = 16'h0001;
	logic [15:0] letter_ms      = 16'h0003;
	logic [15:0] period_ms      = 16'h0040;
	logic        vor_mode;
	logic        landing_system_mode;
	logic        direction_finder_mode;
	logic        conflict;
	logic [11:0] carrier_khz;
	logic [15:0] ident_freq_hz;
	logic        marker_key;
	logic        ident_tone;
	int          err_count = 0;
	int          n_tests   = 0;
	int          cycles    = 0;
	int          m_carrier = 190;        // Model of the settings
	int          m_ident   = 1020;
	int          m_mode    = 0;          // 0 none, 1 vor, 2 landing, 3 df

	avionic_morse_keying_timer #(.TICK_CYCLES(TC)) DUT (
		.clk(clk), .rst_b(rst_b),
		.activate_vor(req[0]), .activate_landing(req[1]), .activate_df(req[2]),
		.deactivate_all(req[3]), .set_defaults(set_defaults),
		.carrier_wr(carrier_wr), .carrier_khz_in(carrier_khz_in),
		.ident_freq_wr(ident_freq_wr), .ident_freq_in(ident_freq_in),
		.pulsed_marker(pulsed_marker), .marker_type(marker_type),
		.ident_enable(ident_enable), .code_elems(code_elems), .code_count(code_count),
		.user_scheme(user_scheme), .dot_ms(dot_ms), .dash_ms(dash_ms), .sym_ms(sym_ms),
		.letter_ms(letter_ms), .period_ms(period_ms),
		.vor_mode(vor_mode), .landing_system_mode(landing_system_mode),
		.direction_finder_mode(direction_finder_mode), .conflict(conflict),
		.carrier_khz(carrier_khz), .ident_freq_hz(ident_freq_hz),
		.marker_key(marker_key), .ident_tone(ident_tone));

	// ----------------------------------------------------------------
	// Clock and hang guard
	// ----------------------------------------------------------------
	initial begin
		forever #50 clk = ~clk;
	end

	// Whole plan needs about 60k cycles; beyond 90k means a hang
	always @(posedge clk) begin
		cycles++;
		if (cycles == 90000) begin
			err_count++;
			print_verdict();
		end
	end

	// ----------------------------------------------------------------
	// Compare and measure helpers
	// ----------------------------------------------------------------
	task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check_val

	task automatic check_len(input string what, input int exp, input int got);
		n_tests++;
		if (got != exp) begin
			err_count++;
			$display("mismatch %s expected %0d seen %0d", what, exp, got);
		end
	endtask : check_len

	// Cycles until the chosen key changes, counted on falling edges
	task automatic run_len(input bit sel, input int lim, output int n);
		logic lvl;
		lvl = sel ? ident_tone : marker_key;
		n = 0;
		while ((sel ? ident_tone : marker_key) === lvl && n < lim) begin
			@(negedge clk);
			n++;
		end
	endtask : run_len

	task automatic print_verdict();
		if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : print_verdict

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Random carrier (edges of the band favoured), then a random request
	task automatic settings_step();
		int c, f, a;
		bit inr;
		c = $urandom_range(5, 0);
		c = (c == 0) ? 189 : (c == 1) ? 190 : (c == 2) ? 1750 : (c == 3) ? 1751
			: $urandom_range(4095, 0);
		f = $urandom_range(65535, 0);
		@(posedge clk);
		carrier_wr <= 1'b1;
		carrier_khz_in <= c[11:0];
		ident_freq_wr <= 1'b1;
		ident_freq_in <= f[15:0];
		@(posedge clk);
		carrier_wr <= 1'b0;
		ident_freq_wr <= 1'b0;
		m_carrier = c;
		m_ident = f;
		inr = (c >= 190 && c <= 1750);
		if (!inr && m_mode == 3) m_mode = 0;
		repeat (2) @(posedge clk);
		a = $urandom_range(4, 0);
		if (a == 4) set_defaults <= 1'b1;
		else req[a] <= 1'b1;
		@(posedge clk);
		req <= 4'h0;
		set_defaults <= 1'b0;
		if (a == 4) begin
			m_carrier = 190;
			m_ident = 1020;
		end else if (a == 3) m_mode = 0;
		else if (a != 2 || inr) m_mode = a + 1;
		@(posedge clk);
		@(negedge clk);
		check_val("carrier_khz", m_carrier, carrier_khz);
		check_val("ident_freq_hz", m_ident, ident_freq_hz);
		check_val("conflict", !(m_carrier >= 190 && m_carrier <= 1750), conflict);
		check_val("modes", (m_mode == 0) ? 0 : (1 << (m_mode - 1)),
			{direction_finder_mode, landing_system_mode, vor_mode});
	endtask : settings_step

	// Restart the pattern, drop the first phase, then follow two rounds
	task automatic marker_test(input logic [1:0] t);
		int exp[$];
		int n, k;
		if (t == 2'h1) exp = '{375, 125, 83, 83};
		else if (t == 2'h2) exp = '{83, 83};
		else exp = '{375, 125};
		@(posedge clk);
		pulsed_marker <= 1'b0;
		marker_type <= t;
		repeat (3) @(posedge clk);
		pulsed_marker <= 1'b1;
		repeat (2) @(posedge clk);
		@(negedge clk);
		check_val("marker_key first phase", 1, marker_key);
		run_len(0, 10000, n);
		for (k = 1; k <= 2 * exp.size(); k++) begin
			run_len(0, 10000, n);
			check_len("marker run", exp[k % exp.size()] * TC, n);
		end
	endtask : marker_test

	// Random code and lengths; model the marks and gaps of one round
	task automatic ident_test(input bit usr);
		int exp[$];
		int d, da, s, l, cnt, act, n, k;
		logic [31:0] e;
		e = $urandom();
		cnt = $urandom_range(4, 1);
		d = usr ? $urandom_range(6, 1) : $urandom_range(3, 1);
		da = usr ? $urandom_range(6, 1) : 3 * d;
		s = usr ? $urandom_range(6, 1) : d;
		l = usr ? $urandom_range(6, 1) : 3 * d;
		act = 0;
		for (k = 0; k < cnt; k++) begin
			exp.push_back(e[2 * k] ? da : d);
			if (k < cnt - 1) exp.push_back(e[2 * k + 1] ? l : s);
		end
		foreach (exp[k]) act += exp[k];
		exp.push_back(20);                     // Silence left of the period
		@(posedge clk);
		code_elems <= e;
		code_count <= cnt[4:0];
		user_scheme <= usr;
		dot_ms <= 16'(usr ? d : d);
		dash_ms <= 16'(usr ? da : 1);
		sym_ms <= 16'(usr ? s : 1);
		letter_ms <= 16'(usr ? l : 1);
		period_ms <= 16'(act + 20);
		ident_enable <= 1'b1;
		@(negedge clk);
		// Skip to the first long silence so the next round is tick aligned
		for (k = 0; k < 40; k++) begin
			run_len(1, 5000, n);
			if (ident_tone === 1'b1 && n > 15 * TC) break;
		end
		for (k = 0; k < 2 * exp.size(); k++) begin
			run_len(1, 5000, n);
			check_len("ident run", exp[k % exp.size()] * TC, n);
		end
		@(posedge clk);
		ident_enable <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		check_val("ident_tone disabled", 0, ident_tone);
		run_len(1, 500, n);
		check_len("ident silent", 500, n);
	endtask : ident_test

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		int n, k;
		void'($urandom(280));
		repeat (5) @(posedge clk);
		@(negedge clk);
		check_val("reset modes", 0, {direction_finder_mode, landing_system_mode, vor_mode});
		check_val("reset carrier", 190, carrier_khz);
		check_val("reset ident freq", 1020, ident_freq_hz);
		check_val("reset marker_key", 1, marker_key);
		check_val("reset ident_tone", 0, ident_tone);
		@(posedge clk);
		rst_b <= 1'b1;
		for (k = 0; k < 30; k++) settings_step();
		@(negedge clk);
		run_len(0, 3000, n);
		check_len("marker continuous", 3000, n);
		for (k = 0; k < 4; k++) marker_test(k[1:0]);
		@(posedge clk);
		pulsed_marker <= 1'b0;
		for (k = 0; k < 6; k++) ident_test(k[0]);
		@(posedge clk);
		code_count <= 5'h00;
		ident_enable <= 1'b1;
		repeat (2) @(posedge clk);
		@(negedge clk);
		run_len(1, 500, n);
		check_len("ident key down", 500, n);
		check_val("ident key level", 1, ident_tone);
		print_verdict();
	end
endmodule : avionic_morse_keying_timer_test
`default_nettype wire
